// ---- include/ocs_defs.vh ----
// register map, field positions and reset values of the clock switch
`ifndef OCS_DEFS_VH
`define OCS_DEFS_VH

// ==========================================================
// register byte offsets
`define OCS_ADDR_W          12
`define OCS_OFS_RUN_CTRL    12'h000
`define OCS_OFS_CLK_SEL     12'h004
`define OCS_OFS_SUB_SEL     12'h008

// ==========================================================
// oscillator run control fields
`define OCS_RUN_HIGH_STOP   0
`define OCS_RUN_MID_EN      1
`define OCS_RUN_FIXED_ONE   6
`define OCS_RUN_X1_STOP     7

// ==========================================================
// clock source selection fields
`define OCS_SEL_MAIN_ONCHIP 0
`define OCS_SEL_MAIN_STAT   1
`define OCS_SEL_MAIN_SYS    4
`define OCS_SEL_SYS_STAT    5
`define OCS_SEL_SUB_SEL     6
`define OCS_SEL_SUB_STAT    7

// ==========================================================
// subsystem source select fields
`define OCS_SUB_LOW_SEL     0

// ==========================================================
// reset values of the stored bits
`define OCS_RST_HIGH_STOP   1'b0
`define OCS_RST_MID_EN      1'b0
`define OCS_RST_X1_STOP     1'b1
`define OCS_RST_MAIN_ONCHIP 1'b0
`define OCS_RST_MAIN_SYS    1'b0
`define OCS_RST_SUB_SEL     1'b0
`define OCS_RST_LOW_SEL     1'b0

// ==========================================================
// source one-hot codes and break-before-make gap
`define OCS_SRC_NONE        3'h0
`define OCS_SRC_HIGH        3'h1
`define OCS_SRC_MID         3'h2
`define OCS_SRC_LOW         3'h4
`define OCS_GAP_CYC         2'h2

`endif

// ---- rtl/ocs_switch.v ----
// break-before-make selector of the cpu/peripheral clock source
`timescale 1ns/1ps
`include "ocs_defs.vh"

module ocs_switch (
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// requested sources
	input  wire       main_onchip_source_select,
	input  wire       subsystem_select,
	// oscillator running indications
	input  wire       high_osc_ready,
	input  wire       mid_osc_ready,
	input  wire       low_osc_ready,
	// gate selects and status
	output wire [2:0] clk_gate_sel,
	output wire       main_onchip_source_status,
	output wire       subsystem_active_status
);

	// ======================================================
	// states
	localparam [2:0] ST_RUN   = 3'b001;
	localparam [2:0] ST_BREAK = 3'b010;
	localparam [2:0] ST_MAKE  = 3'b100;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [1:0] gap_q;
	reg [1:0] gap_d;
	reg [2:0] gate_q;
	reg [2:0] gate_d;
	reg       main_q;
	reg       main_d;
	reg       sub_q;
	reg       sub_d;
	reg [2:0] tgt_q;
	reg [2:0] tgt_d;

	// ======================================================
	// wanted source and its readiness
	wire [2:0] want_src = subsystem_select ? `OCS_SRC_LOW :
		(main_onchip_source_select ? `OCS_SRC_MID : `OCS_SRC_HIGH);
	wire       want_rdy = subsystem_select ? low_osc_ready :
		(main_onchip_source_select ? mid_osc_ready : high_osc_ready);
	wire       main_rdy = main_onchip_source_select ? mid_osc_ready :
		high_osc_ready;

	// ======================================================
	// next state
	always @* begin
		state_d = state_q;
		gap_d   = gap_q;
		gate_d  = gate_q;
		main_d  = main_q;
		sub_d   = sub_q;
		tgt_d   = tgt_q;
		case (state_q)
			ST_RUN: begin
				// switch only to a running source
				if (want_src != gate_q && want_rdy) begin
					tgt_d   = want_src;
					gate_d  = `OCS_SRC_NONE;
					gap_d   = `OCS_GAP_CYC;
					state_d = ST_BREAK;
				end else if (subsystem_select && sub_q &&
					main_onchip_source_select != main_q && main_rdy) begin
					// main path retargeted while idle under low clock
					main_d = main_onchip_source_select;
				end
			end
			ST_BREAK: begin
				// all gates closed for the gap
				gap_d = gap_q - 2'h1;
				if (gap_q == 2'h1)
					state_d = ST_MAKE;
			end
			ST_MAKE: begin
				// new source now drives the clock
				gate_d  = tgt_q;
				// main on-chip status after the make
				if (tgt_q != `OCS_SRC_LOW)
					main_d = (tgt_q == `OCS_SRC_MID);
				sub_d   = (tgt_q == `OCS_SRC_LOW);
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RUN;
			gap_q   <= 2'h0;
			gate_q  <= `OCS_SRC_HIGH;
			main_q  <= 1'b0;
			sub_q   <= 1'b0;
			tgt_q   <= `OCS_SRC_HIGH;
		end else begin
			state_q <= state_d;
			gap_q   <= gap_d;
			gate_q  <= gate_d;
			main_q  <= main_d;
			sub_q   <= sub_d;
			tgt_q   <= tgt_d;
		end
	end

	assign clk_gate_sel              = gate_q;
	assign main_onchip_source_status = main_q;
	assign subsystem_active_status   = sub_q;

endmodule // ocs_switch

// ---- rtl/ocs_clock_ctrl.v ----
// on-chip oscillator control registers and clock source switching
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ocs_defs.vh"

module ocs_clock_ctrl (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// oscillator running indications
	input  wire        high_osc_ready,
	input  wire        mid_osc_ready,
	input  wire        low_osc_ready,
	// oscillator enables
	output wire        high_osc_en,
	output wire        mid_osc_en,
	output wire        low_osc_en,
	output wire        x1_osc_en,
	// cpu/peripheral clock gate selects, one-hot high/mid/low
	output wire [2:0]  clk_gate_sel
);

	// ======================================================
	// stored control bits
	reg high_osc_stop_q;
	reg mid_osc_enable_q;
	reg x1_osc_stop_q;
	reg main_onchip_source_select_q;
	reg main_system_source_select_q;
	reg subsystem_select_q;
	reg low_osc_select_q;

	wire main_onchip_source_status;
	wire subsystem_active_status;

	// ======================================================
	// address decode
	function [1:0] dec_reg;
		input [11:0] a;
		begin
			case (a)
				`OCS_OFS_RUN_CTRL: dec_reg = 2'h1;
				`OCS_OFS_CLK_SEL:  dec_reg = 2'h2;
				`OCS_OFS_SUB_SEL:  dec_reg = 2'h3;
				default:           dec_reg = 2'h0;
			endcase
		end
	endfunction

	wire [1:0] reg_idx  = dec_reg(paddr);
	wire       setup    = psel && !penable;
	wire       wr_acc   = psel && penable && pwrite;

	assign pready = 1'b1;

	// ======================================================
	// read data image
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		case (reg_idx)
			2'h1: begin
				rd_byte[`OCS_RUN_HIGH_STOP] = high_osc_stop_q;
				rd_byte[`OCS_RUN_MID_EN]    = mid_osc_enable_q;
				rd_byte[`OCS_RUN_FIXED_ONE] = 1'b1;
				rd_byte[`OCS_RUN_X1_STOP]   = x1_osc_stop_q;
			end
			2'h2: begin
				rd_byte[`OCS_SEL_MAIN_ONCHIP] = main_onchip_source_select_q;
				rd_byte[`OCS_SEL_MAIN_STAT]   = main_onchip_source_status;
				rd_byte[`OCS_SEL_MAIN_SYS]    = main_system_source_select_q;
				rd_byte[`OCS_SEL_SYS_STAT]    = 1'b0;
				rd_byte[`OCS_SEL_SUB_SEL]     = subsystem_select_q;
				rd_byte[`OCS_SEL_SUB_STAT]    = subsystem_active_status;
			end
			2'h3: begin
				rd_byte[`OCS_SUB_LOW_SEL] = low_osc_select_q;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// ======================================================
	// apb answer, captured in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= {24'h00_0000, rd_byte};
			pslverr <= (reg_idx == 2'h0);
		end
	end

	// ======================================================
	// register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_osc_stop_q             <= `OCS_RST_HIGH_STOP;
			mid_osc_enable_q            <= `OCS_RST_MID_EN;
			x1_osc_stop_q               <= `OCS_RST_X1_STOP;
			main_onchip_source_select_q <= `OCS_RST_MAIN_ONCHIP;
			main_system_source_select_q <= `OCS_RST_MAIN_SYS;
			subsystem_select_q          <= `OCS_RST_SUB_SEL;
			low_osc_select_q            <= `OCS_RST_LOW_SEL;
		end else if (wr_acc) begin
			case (reg_idx)
				2'h1: begin
					high_osc_stop_q  <= pwdata[`OCS_RUN_HIGH_STOP];
					mid_osc_enable_q <= pwdata[`OCS_RUN_MID_EN];
					x1_osc_stop_q    <= pwdata[`OCS_RUN_X1_STOP];
				end
				2'h2: begin
					main_onchip_source_select_q <=
						pwdata[`OCS_SEL_MAIN_ONCHIP];
					main_system_source_select_q <=
						pwdata[`OCS_SEL_MAIN_SYS];
					subsystem_select_q <= pwdata[`OCS_SEL_SUB_SEL];
				end
				2'h3: begin
					low_osc_select_q <= pwdata[`OCS_SUB_LOW_SEL];
				end
				default: begin
					low_osc_select_q <= low_osc_select_q;
				end
			endcase
		end
	end

	// ======================================================
	// oscillator enables; the source in use is never stopped
	// active source held running
	assign high_osc_en = !high_osc_stop_q || clk_gate_sel[0];
	// middle oscillator runs while enabled or in use
	assign mid_osc_en  = mid_osc_enable_q || clk_gate_sel[1];
	assign low_osc_en  = low_osc_select_q || clk_gate_sel[2];
	assign x1_osc_en   = !x1_osc_stop_q;

	// ======================================================
	// source switch
	ocs_switch u_switch (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.main_onchip_source_select (main_onchip_source_select_q),
		.subsystem_select          (subsystem_select_q),
		.high_osc_ready            (high_osc_ready),
		.mid_osc_ready             (mid_osc_ready),
		.low_osc_ready             (low_osc_ready && low_osc_select_q),
		.clk_gate_sel              (clk_gate_sel),
		.main_onchip_source_status (main_onchip_source_status),
		.subsystem_active_status   (subsystem_active_status)
	);

endmodule // ocs_clock_ctrl

// ---- testbench/ocs_clock_ctrl_properties.sv ----
// port checker of the on-chip oscillator clock switch
`timescale 1ns/1ps
module ocs_clock_ctrl_props (
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// apb slave
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire [31:0] prdata,
	input wire        pslverr,
	// oscillators
	input wire        high_osc_ready,
	input wire        mid_osc_ready,
	input wire        low_osc_ready,
	input wire        high_osc_en,
	input wire        mid_osc_en,
	input wire        low_osc_en,
	input wire        x1_osc_en,
	input wire [2:0]  clk_gate_sel
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite;
	wire rd = psel && !penable && !pwrite;
	// ==========================================================
	// assertions
	a_mid_en_start: assert property (
		wr && paddr == 12'h000 && pwdata[1] |=> mid_osc_en)
		else $error("mid oscillator not started");
	a_low_en_start: assert property (
		wr && paddr == 12'h008 && pwdata[0] |=> low_osc_en)
		else $error("low oscillator not started");
	a_sub_fixed_zero: assert property (
		rd && paddr == 12'h008 |=> prdata[31:1] == 31'h0000_0000)
		else $error("subsystem register spare bits set");
	a_gate_one_hot: assert property ($onehot0(clk_gate_sel))
		else $error("two clock gates open");
	a_gap_length: assert property (
		clk_gate_sel != 3'h0 ##1 clk_gate_sel == 3'h0
		|-> clk_gate_sel == 3'h0 [*3] ##1 $onehot(clk_gate_sel))
		else $error("switch gap length wrong");
	a_mid_ready_used: assert property (
		$rose(clk_gate_sel[1]) |-> mid_osc_ready)
		else $error("mid gate opened while not running");
	a_main_stat_read: assert property (
		rd && paddr == 12'h004 && clk_gate_sel[1] |=> prdata[1])
		else $error("main status not shown");
	a_sub_stat_read: assert property (
		rd && paddr == 12'h004 |=> prdata[7] == $past(clk_gate_sel[2]))
		else $error("subsystem status wrong");
	a_active_kept_on: assert property (
		(clk_gate_sel & ~{low_osc_en, mid_osc_en, high_osc_en}) == 3'h0)
		else $error("active oscillator stopped");
	c_mid_run: cover property (clk_gate_sel == 3'h2);
	c_low_run: cover property (clk_gate_sel == 3'h4);
	c_sel_write: cover property (wr && paddr == 12'h004);
endmodule // ocs_clock_ctrl_props

bind ocs_clock_ctrl ocs_clock_ctrl_props u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .high_osc_ready(high_osc_ready),
	.mid_osc_ready(mid_osc_ready), .low_osc_ready(low_osc_ready),
	.high_osc_en(high_osc_en), .mid_osc_en(mid_osc_en),
	.low_osc_en(low_osc_en), .x1_osc_en(x1_osc_en),
	.clk_gate_sel(clk_gate_sel));

// ---- testbench/ocs_clock_ctrl_tb.sv ----
// self-checking bench of the on-chip oscillator clock switch
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module ocs_clock_ctrl_tb;
	logic        pclk, presetn, psel, penable, pwrite, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, rdat;
	logic        hrdy, mrdy, lrdy;
	logic [15:0] rnd;
	wire         pready, pslverr, hen, men, len, xen;
	wire [31:0]  prdata;
	wire [2:0]   gate;
	int          failures, n_tests, cyc, act;
	int          m[3];
	ocs_clock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .high_osc_ready(hrdy), .mid_osc_ready(mrdy),
		.low_osc_ready(lrdy), .high_osc_en(hen), .mid_osc_en(men),
		.low_osc_en(len), .x1_osc_en(xen), .clk_gate_sel(gate));
	// ==========================================================
	// model and bus tasks
	function automatic logic [31:0] exp_rd(input logic [11:0] a);
		int ms;
		ms = (act == 0) ? 0 : (act == 1) ? 1 : (m[1] & 1);
		if (a == 12'h000) return (m[0] & 8'h83) | 8'h40;
		if (a == 12'h004)
			return (m[1] & 8'h51) | (ms << 1) | ((act == 2) ? 8'h80 : 8'h00);
		if (a == 12'h008) return m[2] & 1;
		return 0;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
		pwdata <= {rnd, 8'h00, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 0; penable <= 0;
		if (w && a < 12'h00C) m[a >> 2] = d;
	endtask
	task automatic rchk(input logic [11:0] a);
		apb(0, a, 8'h00);
		`CHK(rdat, exp_rd(a))
		`CHK(perr, a > 12'h008)
		`CHK(pready, 1'b1)
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic close_out;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// clock, reset, timeout
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			failures++;
			close_out;
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
		pwdata = 0; hrdy = 1; mrdy = 0; lrdy = 0; rnd = 16'd37375;
		m = '{8'hC0, 0, 0}; act = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rchk(12'h000); rchk(12'h004); rchk(12'h008);
		`CHK({hen, men, len, xen, gate}, 7'b1000_001)
		$display("test reset done");
		apb(1, 12'h000, 8'hC2); run(1); `CHK(men, 1'b1)
		run(40);
		@(posedge pclk) mrdy <= 1;
		apb(1, 12'h004, 8'h01); run(6); act = 1; `CHK(gate, 3'h2)
		rchk(12'h004); apb(1, 12'h000, 8'hC3); run(1);
		`CHK(hen, 1'b0)
		rchk(12'h000); $display("test high to mid done");
		apb(1, 12'h008, 8'h01); run(1); `CHK(len, 1'b1)
		run(2100);
		apb(1, 12'h004, 8'h41); run(10); `CHK(gate, 3'h2)
		rchk(12'h004); lrdy <= 1; run(6); act = 2;
		`CHK(gate, 3'h4)
		rchk(12'h004); apb(1, 12'h000, 8'hC1); run(1);
		`CHK(men, 1'b0)
		@(posedge pclk) mrdy <= 0;
		apb(1, 12'h004, 8'h40); run(1); rchk(12'h004);
		$display("test mid to low done");
		apb(1, 12'h000, 8'h40); apb(1, 12'h004, 8'h00); run(6); act = 0;
		`CHK(gate, 3'h1)
		`CHK(xen, 1'b1)
		rchk(12'h004); $display("test low to high done");
		apb(1, 12'h00C, 8'hFF); rchk(12'h00C); rchk(12'h000);
		apb(1, 12'h004, 8'h10); rchk(12'h004);
		$display("test unmapped done");
		close_out;
	end
endmodule // ocs_clock_ctrl_tb
